/* File: design/csef_pkg.sv */
package csef_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_RXBUF = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ST = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h10;

    // Status bit positions
    localparam int unsigned B_RXFULL = 6;
    localparam int unsigned B_OVR = 5;
    localparam int unsigned B_CERR = 4;
    localparam int unsigned B_PAR = 3;

    // Control bit positions
    localparam int unsigned B_RXEN = 0;
    localparam int unsigned B_SYNC = 1;
    localparam int unsigned B_CARD = 2;

    // Event index in interrupt registers
    localparam int unsigned NEV = 4;
    localparam int unsigned E_RXFULL = 0;
    localparam int unsigned E_OVR = 1;
    localparam int unsigned E_CERR = 2;
    localparam int unsigned E_PAR = 3;

    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [NEV-1:0] EV_NONE = 4'h0;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } csef_bus_t;

    typedef struct packed {
        logic done;
        logic parity_err;
        logic [DATA_W-1:0] data;
    } csef_rx_t;

    typedef struct packed {
        logic rx_full;
        logic ovr;
        logic cerr;
        logic par;
    } csef_flags_t;

    typedef struct packed {
        csef_flags_t flags;
        csef_flags_t armed;
        logic [DATA_W-1:0] rx_buffer;
        logic [2:0] ctrl;
        logic [NEV-1:0] irq_st;
        logic [NEV-1:0] irq_mask;
        logic [DATA_W-1:0] rdata;
        logic rx_accept;
        logic tx_allow;
        logic irq;
    } csef_state_t;
endpackage

/* File: design/csef_top.sv */
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/100ps

// How it works
// - Completion without parity error while full sets overrun
// - Overrun keeps old byte, drops new
// - Overrun set blocks further reception
// - Sync mode: overrun also blocks transmit
// - Overrun clears on read one, write zero
// - Receive disable leaves overrun untouched
// - Sampled low error signal sets flag
// - Error flag clears on read, write zero
// - Parity error on reception sets flag
// - Parity error loads buffer, not full
// - Parity set blocks reception, sync transmit
// - Parity clears on read one, write zero
// - Receive disable leaves parity untouched
// - Writing one to flags does nothing
// - Normal end loads buffer, sets full
module csef_top (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Register port
    input wire csef_pkg::csef_bus_t bus_i,
    output logic [csef_pkg::DATA_W-1:0] rd_data_o,
    // Receiver core
    input wire csef_pkg::csef_rx_t rx_i,
    output logic rx_accept_o,
    output logic tx_allow_o,
    // Card error signal sampling
    input wire logic err_sample_i,
    input wire logic err_line_i,
    // Interrupt
    output logic irq_o
);
    csef_pkg::csef_state_t s_r;
    csef_pkg::csef_state_t s_nxt;

    logic wr_status;
    logic rd_status;
    logic wr_ctrl;
    logic wr_irq_st;
    logic wr_irq_mask;
    logic rx_open;
    logic rx_good;
    logic rx_over;
    logic rx_par;
    logic card_err;
    logic [csef_pkg::NEV-1:0] ev;
    csef_pkg::csef_flags_t clr;
    logic [csef_pkg::DATA_W-1:0] stat_word;
    logic [csef_pkg::DATA_W-1:0] rd_word;

    assign wr_status = bus_i.wr
        && (bus_i.addr == csef_pkg::OFF_STATUS);
    assign rd_status = bus_i.rd
        && (bus_i.addr == csef_pkg::OFF_STATUS);
    assign wr_ctrl = bus_i.wr
        && (bus_i.addr == csef_pkg::OFF_CTRL);
    assign wr_irq_st = bus_i.wr
        && (bus_i.addr == csef_pkg::OFF_IRQ_ST);
    assign wr_irq_mask = bus_i.wr
        && (bus_i.addr == csef_pkg::OFF_IRQ_MASK);

    // Reception stays shut while the overrun or parity flag stands
    assign rx_open = s_r.ctrl[csef_pkg::B_RXEN]
        && !s_r.flags.ovr && !s_r.flags.par;

    assign rx_par = rx_open && rx_i.done
        && rx_i.parity_err;
    assign rx_over = rx_open && rx_i.done
        && !rx_i.parity_err && s_r.flags.rx_full;
    assign rx_good = rx_open && rx_i.done
        && !rx_i.parity_err && !s_r.flags.rx_full;

    // Error signal only meaningful in card mode
    assign card_err = err_sample_i && !err_line_i
        && s_r.ctrl[csef_pkg::B_CARD];

    assign ev[csef_pkg::E_RXFULL] = rx_good;
    assign ev[csef_pkg::E_OVR] = rx_over;
    assign ev[csef_pkg::E_CERR] = card_err;
    assign ev[csef_pkg::E_PAR] = rx_par;

    // Clear needs an earlier read of one and a written zero
    assign clr.rx_full = wr_status && s_r.armed.rx_full
        && !bus_i.wdata[csef_pkg::B_RXFULL];
    assign clr.ovr = wr_status && s_r.armed.ovr
        && !bus_i.wdata[csef_pkg::B_OVR];
    assign clr.cerr = wr_status && s_r.armed.cerr
        && !bus_i.wdata[csef_pkg::B_CERR];
    assign clr.par = wr_status && s_r.armed.par
        && !bus_i.wdata[csef_pkg::B_PAR];

    always_comb begin
        stat_word = csef_pkg::ZERO_BYTE;
        stat_word[csef_pkg::B_RXFULL] = s_r.flags.rx_full;
        stat_word[csef_pkg::B_OVR] = s_r.flags.ovr;
        stat_word[csef_pkg::B_CERR] = s_r.flags.cerr;
        stat_word[csef_pkg::B_PAR] = s_r.flags.par;
    end

    always_comb begin
        rd_word = csef_pkg::ZERO_BYTE;
        unique case (bus_i.addr)
            csef_pkg::OFF_STATUS: begin
                rd_word = stat_word;
            end
            csef_pkg::OFF_RXBUF: begin
                rd_word = s_r.rx_buffer;
            end
            csef_pkg::OFF_CTRL: begin
                rd_word[2:0] = s_r.ctrl;
            end
            csef_pkg::OFF_IRQ_ST: begin
                rd_word[csef_pkg::NEV-1:0] = s_r.irq_st;
            end
            csef_pkg::OFF_IRQ_MASK: begin
                rd_word[csef_pkg::NEV-1:0] = s_r.irq_mask;
            end
            default: begin
                rd_word = csef_pkg::ZERO_BYTE;
            end
        endcase
    end

    always_comb begin
        s_nxt = s_r;

        // Read data valid only the cycle after a read
        s_nxt.rdata = bus_i.rd ? rd_word : csef_pkg::ZERO_BYTE;

        if (wr_ctrl) begin
            // Flags are not touched by receive disable
            s_nxt.ctrl = bus_i.wdata[2:0];
        end

        // Any status write ends the read-then-write pairing
        if (wr_status) begin
            s_nxt.armed = '0;
        end
        if (rd_status) begin
            s_nxt.armed.rx_full = s_r.armed.rx_full
                | s_r.flags.rx_full;
            s_nxt.armed.ovr = s_r.armed.ovr | s_r.flags.ovr;
            s_nxt.armed.cerr = s_r.armed.cerr | s_r.flags.cerr;
            s_nxt.armed.par = s_r.armed.par | s_r.flags.par;
        end

        // Clears first, then sets so an event wins
        if (clr.rx_full) begin
            s_nxt.flags.rx_full = 1'b0;
        end
        if (clr.ovr) begin
            s_nxt.flags.ovr = 1'b0;
        end
        if (clr.cerr) begin
            s_nxt.flags.cerr = 1'b0;
        end
        if (clr.par) begin
            s_nxt.flags.par = 1'b0;
        end

        if (rx_good) begin
            s_nxt.rx_buffer = rx_i.data;
            s_nxt.flags.rx_full = 1'b1;
        end
        if (rx_over) begin
            // Buffer keeps the earlier byte
            s_nxt.flags.ovr = 1'b1;
        end
        if (rx_par) begin
            s_nxt.rx_buffer = rx_i.data;
            s_nxt.flags.par = 1'b1;
        end
        if (card_err) begin
            s_nxt.flags.cerr = 1'b1;
        end

        if (wr_irq_mask) begin
            s_nxt.irq_mask = bus_i.wdata[csef_pkg::NEV-1:0];
        end
        for (int i = 0; i < csef_pkg::NEV; i++) begin
            if (wr_irq_st && bus_i.wdata[i]) begin
                s_nxt.irq_st[i] = 1'b0;
            end
            if (ev[i]) begin
                s_nxt.irq_st[i] = 1'b1;
            end
        end
        s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);

        s_nxt.rx_accept = s_nxt.ctrl[csef_pkg::B_RXEN]
            && !s_nxt.flags.ovr && !s_nxt.flags.par;
        s_nxt.tx_allow = !s_nxt.ctrl[csef_pkg::B_SYNC]
            || (!s_nxt.flags.ovr && !s_nxt.flags.par);
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_r.flags <= '0;
            s_r.armed <= '0;
            s_r.rx_buffer <= csef_pkg::ZERO_BYTE;
            s_r.ctrl <= csef_pkg::CTRL_RST;
            s_r.irq_st <= csef_pkg::EV_NONE;
            s_r.irq_mask <= csef_pkg::EV_NONE;
            s_r.rdata <= csef_pkg::ZERO_BYTE;
            s_r.rx_accept <= 1'b0;
            s_r.tx_allow <= 1'b1;
            s_r.irq <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rd_data_o = s_r.rdata;
    assign rx_accept_o = s_r.rx_accept;
    assign tx_allow_o = s_r.tx_allow;
    assign irq_o = s_r.irq;
endmodule

/* File: dv/csef_assertions.sv */
`timescale 1ns/100ps
module csef_assertions (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Watched ports
    input wire csef_pkg::csef_bus_t bus_i,
    input wire logic [csef_pkg::DATA_W-1:0] rd_data_o,
    input wire csef_pkg::csef_rx_t rx_i,
    input wire logic rx_accept_o,
    input wire logic tx_allow_o,
    input wire logic err_sample_i,
    input wire logic err_line_i,
    input wire logic irq_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_ok;
        rx_i.done && !rx_i.parity_err && rx_accept_o;
    endsequence
    sequence s_quiet;
        !rx_i.done && !err_sample_i && !bus_i.wr;
    endsequence
    a_reset_vals: assert property (disable iff (1'b0) rst_i |=>
        !irq_o && !rx_accept_o && tx_allow_o && rd_data_o == 8'h00)
        else $error("outputs not at reset values");
    a_rd_idle: assert property (!bus_i.rd |=> rd_data_o == 8'h00)
        else $error("read data not idle");
    a_ovr_block: assert property (
        s_ok ##1 s_ok |-> ##[1:2] !rx_accept_o)
        else $error("reception while full did not block");
    a_par_block: assert property (
        rx_i.done && rx_i.parity_err && rx_accept_o |-> ##[1:2] !rx_accept_o)
        else $error("parity error did not block");
    a_acc_hold: assert property (
        (!bus_i.wr)[*2] ##0 !rx_accept_o |=> !rx_accept_o)
        else $error("reception resumed without a write");
    a_tx_hold: assert property (
        (!bus_i.wr)[*2] ##0 !tx_allow_o |=> !tx_allow_o)
        else $error("transmit resumed without a write");
    a_tx_link: assert property (!tx_allow_o |-> !rx_accept_o)
        else $error("transmit blocked without a flag");
    a_irq_cause: assert property (s_quiet[*2] ##0 !irq_o |=> !irq_o)
        else $error("interrupt rose without an event");
endmodule

bind csef_top csef_assertions u_csef_assertions (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .bus_i(bus_i), .rd_data_o(rd_data_o), .rx_i(rx_i),
    .rx_accept_o(rx_accept_o), .tx_allow_o(tx_allow_o),
    .err_sample_i(err_sample_i), .err_line_i(err_line_i), .irq_o(irq_o));

/* File: dv/csef_card_model.sv */
`timescale 1ns/100ps
module csef_card_model (
    // Clock
    input wire logic clk_sys_i,
    // Receiver side and error slot
    output csef_pkg::csef_rx_t rx_o,
    output logic err_sample_o,
    output logic err_line_o
);
    logic tog = 1'b0;
    logic lvl = 1'b1;
    initial begin
        rx_o = '0;
        err_sample_o = 1'b0;
    end
    // Line wanders outside the slot so no stale level is seen
    always @(posedge clk_sys_i) tog <= ~tog;
    assign err_line_o = err_sample_o ? lvl : tog;
    task automatic frames(input logic [7:0] d, input logic pe, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys_i);
            rx_o <= '{1'b1, pe, d + 8'(i)};
        end
        @(posedge clk_sys_i);
        rx_o <= '{1'b0, ~pe, ~d};
    endtask
    task automatic slot(input logic low);
        @(posedge clk_sys_i);
        err_sample_o <= 1'b1;
        lvl <= ~low;
        @(posedge clk_sys_i);
        err_sample_o <= 1'b0;
    endtask
endmodule

/* File: dv/csef_tb_top.sv */
`timescale 1ns/100ps
module csef_tb_top;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    csef_pkg::csef_bus_t bus = '0;
    csef_pkg::csef_rx_t rx;
    logic [7:0] rd_data_o;
    logic acc, tx, irq, smp, lin;
    int failures = 0;
    int compares = 0;
    logic [7:0] exp_q[$];
    logic pend = 1'b0;
    logic [31:0] seed = 32'h98a0_1029;
    logic [7:0] d;
    initial forever #2 clk_sys_i = ~clk_sys_i;
    csef_top u_csef_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_i(bus),
        .rd_data_o(rd_data_o), .rx_i(rx), .rx_accept_o(acc), .tx_allow_o(tx),
        .err_sample_i(smp), .err_line_i(lin), .irq_o(irq));
    csef_card_model u_csef_card_model (.clk_sys_i(clk_sys_i), .rx_o(rx),
        .err_sample_o(smp), .err_line_o(lin));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string n, input logic [7:0] s, e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(posedge clk_sys_i);
        bus <= '{1'b1, 1'b0, a, v};
        @(posedge clk_sys_i);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        exp_q.push_back(e);
        @(posedge clk_sys_i);
        bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys_i);
        bus.rd <= 1'b0;
    endtask
    task automatic lv(input logic [2:0] e);
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check("accept_tx_irq", {5'h00, acc, tx, irq}, {5'h00, e});
    endtask
    task automatic wrap_up();
        if (failures == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        if (pend) begin
            check("rd_data_o", rd_data_o, exp_q.pop_front());
        end
        pend <= bus.rd;
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        failures++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        lv(3'b010);
        rd(8'h00, 8'h00);
        wr(8'h10, 8'h0f);
        wr(8'h08, 8'h01);
        d = seed[7:0];
        u_csef_card_model.frames(d, 1'b0, 2);
        lv(3'b011);
        rd(8'h00, 8'h60);
        u_csef_card_model.frames(8'h5a, 1'b0, 1);
        rd(8'h04, d);
        wr(8'h08, 8'h00);
        wr(8'h00, 8'hff);
        rd(8'h00, 8'h60);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h0c, 8'h0f);
        lv(3'b010);
        wr(8'h08, 8'h07);
        seed = lfsr(seed);
        d = seed[7:0];
        u_csef_card_model.frames(d, 1'b1, 2);
        lv(3'b001);
        wr(8'h00, 8'h00);
        rd(8'h04, d);
        wr(8'h08, 8'h06);
        rd(8'h00, 8'h08);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h0c, 8'h0f);
        u_csef_card_model.slot(1'b0);
        u_csef_card_model.slot(1'b1);
        rd(8'h00, 8'h10);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h10, 8'h00);
        lv(3'b010);
        wr(8'h10, 8'h04);
        lv(3'b011);
        rd(8'h20, 8'h00);
        repeat (3) @(posedge clk_sys_i);
        wrap_up();
    end
endmodule
